// ==== src/adc_serial_control_sequencer.sv ====
// Serial control byte capture, track/hold timing and SAR sequencing for a
// 10-bit four-input converter. Pins are sampled by the 100 MHz ref_clk_in;
// the analog comparator answers comp_in against sar_trial_out in the same cycle.
// Function
// - Track on falling edge after bit five
// - Hold and convert after eighth bit
// - Negative input: common or minus channel
// - First one after select low starts byte
// - Leading zeros before start are ignored
// - Capture one bit per rising clock edge
// - Byte: start, select, polarity, config, mode
// - Mode bits: full, fast, internal, external
// - Single-ended positive channel mapping
// - Differential pairs, reversed for 101/110
// - Unipolar binary, bipolar two's complement
// - Output on falling edges, MSB first
// - External mode strobe high one period
// - One decision per falling edge, ten
// - External mode: float when deselected
// - Host clock steps external conversion
// - Zero, ten bits, then five zeros
// - Internal mode strobe low under 7.5 us
// - New start after fourth output bit
// - Select toggle aborts, restarts at start
// - Reset: internal mode, strobe high, zeros
`timescale 1ns/10ps
module adc_serial_control_sequencer
    import adc_seq_pkg::*;
(
    // Clock and reset
    input  wire logic      ref_clk_in,
    input  wire logic      rst_n_in,
    // Serial pins from the host
    input  wire logic      cs_n_in,
    input  wire logic      sclk_in,
    input  wire logic      din_in,
    // Serial pins to the host
    output logic           dout_out,
    output logic           dout_oe_out,
    output logic           conversion_strobe_out,
    output logic           conversion_strobe_oe_out,
    // Analog front end
    input  wire logic      comp_in,
    output logic [9:0]     sar_trial_out,
    output mux_sel_s       mux_out,
    output logic           track_out,
    output logic           converting_out,
    // Mode status
    output logic [1:0]     pwr_mode_out,
    output logic           power_down_out
);

    // ********************************************************************
    // Pin sampling and edge detection
    // ********************************************************************
    logic [2:0]  pins_s;
    logic        sclk_prev_q;
    logic        cs_n_prev_q;

    // Resets to the idle pin levels so no false select edge follows reset
    pin_sync #(
        .WIDTH     (3),
        .RESET_VAL (PINS_RESET)
    ) u_pin_sync (
        .clk_in   (ref_clk_in),
        .rst_n_in (rst_n_in),
        .d_in     ({cs_n_in, sclk_in, din_in}),
        .q_out    (pins_s)
    );

    wire cs_n_s     = pins_s[2];
    wire sclk_s     = pins_s[1];
    wire din_s      = pins_s[0];
    wire cs_low     = ~cs_n_s;
    wire sclk_rise  = sclk_s & ~sclk_prev_q;
    wire sclk_fall  = ~sclk_s & sclk_prev_q;
    wire cs_fall_ev = ~cs_n_s & cs_n_prev_q;
    wire cs_rise_ev = cs_n_s & ~cs_n_prev_q;

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            sclk_prev_q <= 1'b0;
            cs_n_prev_q <= 1'b1;
        end
        else
        begin
            sclk_prev_q <= sclk_s;
            cs_n_prev_q <= cs_n_s;
        end
    end

    // ********************************************************************
    // Control byte capture
    // ********************************************************************
    logic [3:0]  in_cnt_q;
    logic [3:0]  in_cnt_d;
    logic [7:0]  in_sr_q;
    logic        cs_toggled_q;
    conv_state_e conv_q;
    logic [4:0]  out_cnt_q;

    wire start_ok  = (conv_q == CONV_IDLE) | cs_toggled_q
                   | ((conv_q == CONV_EXT) & (out_cnt_q >= 5'(OVERLAP_OUT_BITS)));
    wire in_active = (in_cnt_q != 4'h0);
    wire byte_bit  = cs_low & sclk_rise & (in_cnt_q < 4'(CTRL_BITS))
                   & (in_active | (din_s & start_ok));
    wire track_ev  = cs_low & sclk_fall & (in_cnt_q == 4'(TRACK_AFTER_BIT));
    wire byte_done = cs_low & sclk_fall & (in_cnt_q == 4'(CTRL_BITS));
    ctrl_byte_s new_cfg;
    assign new_cfg = ctrl_byte_s'(in_sr_q);
    wire [1:0] new_mode = {new_cfg.power_clock_mode_hi, new_cfg.power_clock_mode_lo};

    always_comb
    begin
        in_cnt_d = in_cnt_q;
        if (!cs_low || byte_done)
            in_cnt_d = 4'h0;
        else if (byte_bit)
            in_cnt_d = in_cnt_q + 4'h1;
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            in_cnt_q <= 4'h0;
            in_sr_q  <= 8'h00;
        end
        else
        begin
            in_cnt_q <= in_cnt_d;
            if (byte_bit)
                in_sr_q <= {in_sr_q[6:0], din_s};
        end
    end

    // Toggle of select during a conversion lets the next start bit in at once
    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            cs_toggled_q <= 1'b0;
        else if (cs_rise_ev && conv_q != CONV_IDLE)
            cs_toggled_q <= 1'b1;
        else if (byte_done)
            cs_toggled_q <= 1'b0;
    end

    // ********************************************************************
    // Track/hold and input multiplexer
    // ********************************************************************
    ctrl_byte_s  cfg_q;
    logic        track_q;
    logic [1:0]  pos_q;

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            track_q <= 1'b0;
            pos_q   <= 2'h0;
            cfg_q   <= ctrl_byte_s'(CFG_RESET);
        end
        else if (byte_done)
        begin
            track_q <= 1'b0;
            cfg_q   <= new_cfg;
        end
        else if (track_ev)
        begin
            track_q <= 1'b1;
            pos_q   <= {in_sr_q[2], in_sr_q[3]};
        end
    end

    // Positive channel is the same in both configurations; only the minus side differs
    assign mux_out.pos_chan   = pos_q;
    assign mux_out.neg_chan   = pos_q ^ 2'h1;
    assign mux_out.neg_is_com = cfg_q.input_config_select;
    assign track_out          = track_q;
    assign pwr_mode_out       = {cfg_q.power_clock_mode_hi, cfg_q.power_clock_mode_lo};
    assign power_down_out     = ~cfg_q.power_clock_mode_hi;
    wire   ext_mode           = (pwr_mode_out == MODE_EXT_CLK);
    wire   bipolar            = ~cfg_q.polarity_select;

    // ********************************************************************
    // Successive approximation sequencer
    // ********************************************************************
    conv_state_e conv_d;
    logic [4:0]  out_cnt_d;
    logic [9:0]  sar_q;
    logic [9:0]  sar_d;
    logic [9:0]  mask_q;
    logic [9:0]  mask_d;
    logic [6:0]  step_q;
    logic [6:0]  step_d;
    logic [9:0]  rd_sr_q;
    logic [9:0]  rd_sr_d;
    logic        dout_q;
    logic        dout_d;
    logic        strobe_q;
    logic        strobe_d;

    wire [9:0] sar_next  = sar_q | (comp_in ? mask_q : 10'h000);
    wire [9:0] result_w  = sar_next ^ (bipolar ? MSB_MASK : 10'h000);
    wire       dec_bit   = comp_in ^ (bipolar & mask_q[9]);
    wire       step_tick = (step_q == 7'(INT_STEP_CYC - 1));

    always_comb
    begin
        conv_d    = conv_q;
        out_cnt_d = out_cnt_q;
        sar_d     = sar_q;
        mask_d    = mask_q;
        step_d    = step_q;
        rd_sr_d   = rd_sr_q;
        dout_d    = dout_q;
        strobe_d  = strobe_q;
        if (byte_done)
        begin
            sar_d     = 10'h000;
            mask_d    = MSB_MASK;
            out_cnt_d = 5'h00;
            step_d    = 7'h00;
            rd_sr_d   = 10'h000;
            dout_d    = 1'b0;
            case (new_mode)
                MODE_EXT_CLK:
                begin
                    conv_d   = CONV_EXT;
                    strobe_d = 1'b1;
                end
                MODE_INT_CLK:
                begin
                    conv_d   = CONV_INT;
                    strobe_d = 1'b0;
                end
                default:
                begin
                    conv_d   = CONV_IDLE;
                    strobe_d = strobe_q;
                end
            endcase
        end
        else
        begin
            case (conv_q)
                CONV_EXT:
                begin
                    if (sclk_fall)
                    begin
                        strobe_d  = 1'b0;
                        out_cnt_d = out_cnt_q + 5'h01;
                        if (mask_q != 10'h000)
                        begin
                            sar_d  = sar_next;
                            mask_d = mask_q >> 1;
                            dout_d = dec_bit;
                        end
                        else
                            dout_d = 1'b0;
                        if (out_cnt_q == 5'(FRAME_OUT_BITS - 1))
                            conv_d = CONV_IDLE;
                    end
                end
                CONV_INT:
                begin
                    step_d = step_tick ? 7'h00 : step_q + 7'h01;
                    if (step_tick)
                    begin
                        sar_d  = sar_next;
                        mask_d = mask_q >> 1;
                        if (mask_q[0])
                        begin
                            conv_d   = CONV_IDLE;
                            strobe_d = 1'b1;
                            rd_sr_d  = result_w;
                        end
                    end
                    if (sclk_fall && cs_low)
                        dout_d = 1'b0;
                end
                CONV_IDLE:
                begin
                    if (sclk_fall && cs_low)
                    begin
                        dout_d  = rd_sr_q[9];
                        rd_sr_d = {rd_sr_q[8:0], 1'b0};
                    end
                end
                default:
                    conv_d = CONV_IDLE;
            endcase
            if (cs_fall_ev && ext_mode)
                strobe_d = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            conv_q    <= CONV_IDLE;
            out_cnt_q <= 5'h00;
            sar_q     <= 10'h000;
            mask_q    <= 10'h000;
            step_q    <= 7'h00;
            rd_sr_q   <= 10'h000;
            dout_q    <= 1'b0;
            strobe_q  <= 1'b1;
        end
        else
        begin
            conv_q    <= conv_d;
            out_cnt_q <= out_cnt_d;
            sar_q     <= sar_d;
            mask_q    <= mask_d;
            step_q    <= step_d;
            rd_sr_q   <= rd_sr_d;
            dout_q    <= dout_d;
            strobe_q  <= strobe_d;
        end
    end

    // ********************************************************************
    // Pin drivers
    // ********************************************************************
    assign dout_out                 = dout_q;
    assign dout_oe_out              = cs_low;
    assign conversion_strobe_out    = strobe_q;
    assign conversion_strobe_oe_out = ~ext_mode | cs_low;
    assign sar_trial_out            = sar_q | mask_q;
    assign converting_out           = (conv_q != CONV_IDLE);

    // ********************************************************************
    // Checks
    // ********************************************************************
    logic [9:0] int_low_cnt_q;

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            int_low_cnt_q <= 10'h000;
        else if (conv_q == CONV_INT)
            int_low_cnt_q <= int_low_cnt_q + 10'h001;
        else
            int_low_cnt_q <= 10'h000;
    end

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    AST_TRACK_AFTER_FIFTH: assert property (track_ev && !byte_done |=> track_q && in_cnt_q >= 4'(TRACK_AFTER_BIT))
        else $error("track not entered after fifth bit");
    AST_HOLD_AFTER_EIGHTH: assert property (byte_done |=> !track_q && in_cnt_q == 4'h0)
        else $error("hold not entered after eighth bit");
    AST_NEG_INPUT_SELECT: assert property (byte_done |=> mux_out.neg_is_com == $past(in_sr_q[2]))
        else $error("negative input select does not follow config bit");
    AST_START_BIT_TAKEN: assert property (cs_low && sclk_rise && !in_active && din_s && start_ok
                                          |=> in_cnt_q == 4'h1 && in_sr_q[0])
        else $error("start bit not taken");
    AST_LEADING_ZERO_IGNORED: assert property (!in_active && sclk_rise && !din_s |=> !in_active)
        else $error("leading zero was counted");
    AST_EXT_STROBE_PULSE: assert property (byte_done && new_mode == MODE_EXT_CLK
                                           |=> strobe_q && conv_q == CONV_EXT)
        else $error("external strobe not raised at byte end");
    AST_EXT_STROBE_HOLD: assert property (conv_q == CONV_EXT && strobe_q && !sclk_fall && !byte_done && !cs_fall_ev
                                          |=> strobe_q)
        else $error("external strobe dropped early");
    AST_EXT_STROBE_DROP: assert property (conv_q == CONV_EXT && sclk_fall && !byte_done |=> !strobe_q)
        else $error("external strobe held past one period");
    AST_EXT_DECISION_OUT: assert property (conv_q == CONV_EXT && sclk_fall && mask_q != 10'h000 && !byte_done
                                           |=> dout_q == $past(dec_bit) && sar_q == $past(sar_next))
        else $error("decision bit not presented");
    AST_EXT_TRAILING_ZERO: assert property (conv_q == CONV_EXT && sclk_fall && mask_q == 10'h000 && !byte_done
                                            |=> !dout_q)
        else $error("trailing bit not zero");
    AST_FLOAT_DESELECTED: assert property (!cs_low |-> !dout_oe_out && (!ext_mode || !conversion_strobe_oe_out))
        else $error("pin driven while deselected");
    AST_INT_STROBE_LOW_MAX: assert property (int_low_cnt_q <= 10'(INT_CONV_MAX_CYC))
        else $error("internal conversion strobe low too long");
    AST_INT_DONE_STROBE: assert property (conv_q == CONV_INT && conv_d == CONV_IDLE && !byte_done
                                          |=> strobe_q && rd_sr_q == $past(result_w))
        else $error("internal conversion end not signalled");

    COV_EXT_CONVERSION: cover property (conv_q == CONV_EXT && out_cnt_q == 5'(FRAME_OUT_BITS - 1) && sclk_fall);
    COV_INT_CONVERSION: cover property (conv_q == CONV_INT ##1 conv_q == CONV_IDLE && strobe_q);
    COV_OVERLAP_START:  cover property (conv_q == CONV_EXT && byte_bit && !in_active);
    COV_ABORT_RESTART:  cover property (cs_toggled_q && byte_done);

endmodule

// ==== src/adc_seq_pkg.sv ====
// Constants, field layouts and state types for the converter serial sequencer.
// Assumes a 100 MHz system clock; all pin timing is sampled against it.
package adc_seq_pkg;

    // ********************************************************************
    // Framing and conversion counts
    // ********************************************************************
    localparam int CTRL_BITS        = 8;
    localparam int TRACK_AFTER_BIT  = 5;
    localparam int RESULT_BITS      = 10;
    localparam int OVERLAP_OUT_BITS = 4;
    localparam int FRAME_OUT_BITS   = 15;

    // ********************************************************************
    // Internal clock conversion timing
    // ********************************************************************
    localparam int CLK_PERIOD_NS    = 10;
    localparam int INT_CONV_MAX_NS  = 7500;
    localparam int INT_CONV_MAX_CYC = INT_CONV_MAX_NS / CLK_PERIOD_NS;
    localparam int INT_STEP_CYC     = INT_CONV_MAX_CYC / (RESULT_BITS + 1);

    // ********************************************************************
    // Power and clock mode codes, reset values
    // ********************************************************************
    localparam logic [1:0] MODE_FULL_PD = 2'h0;
    localparam logic [1:0] MODE_FAST_PD = 2'h1;
    localparam logic [1:0] MODE_INT_CLK = 2'h2;
    localparam logic [1:0] MODE_EXT_CLK = 2'h3;
    localparam logic [7:0] CFG_RESET    = 8'h02;
    localparam logic [2:0] PINS_RESET   = 3'h4;
    localparam logic [9:0] MSB_MASK     = 10'h200;

    typedef struct packed {
        logic       start;
        logic       chan_select_bit2;
        logic       chan_select_bit1;
        logic       chan_select_bit0;
        logic       polarity_select;
        logic       input_config_select;
        logic       power_clock_mode_hi;
        logic       power_clock_mode_lo;
    } ctrl_byte_s;

    typedef struct packed {
        logic [1:0] pos_chan;
        logic [1:0] neg_chan;
        logic       neg_is_com;
    } mux_sel_s;

    typedef enum logic [1:0] {
        CONV_IDLE,
        CONV_EXT,
        CONV_INT
    } conv_state_e;

endpackage

// ==== src/pin_sync.sv ====
// Two-stage synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous to clk_in.
`timescale 1ns/10ps
module pin_sync #(
    parameter int               WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    // Pins in, synchronised copy out
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] q_out
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            meta_q <= RESET_VAL;
            sync_q <= RESET_VAL;
        end
        else
        begin
            meta_q <= d_in;
            sync_q <= meta_q;
        end
    end

    assign q_out = sync_q;

endmodule

// ==== tb/host_spi_model.sv ====
// Host serial master model: chip select, mode zero serial clock, data in/out.
// Assumes the device answers within half a serial clock of each falling edge.
`timescale 1ns/10ps
module host_spi_model (
    // Serial pins to the device
    output logic        cs_n_out,
    output logic        sclk_out,
    output logic        din_out,
    // Serial pins from the device
    input  wire logic   dout_in,
    input  wire logic   dout_oe_in,
    input  wire logic   strobe_in,
    input  wire logic   strobe_oe_in
);
    // ********************************************************************
    // Link timing and captured replies
    // ********************************************************************
    localparam int HALF_NS = 80;
    logic        dout_last;
    logic [31:0] rx_q;
    logic [31:0] strb_q;

    initial
    begin
        cs_n_out  = 1'b1;
        sclk_out  = 1'b0;
        din_out   = 1'b0;
        dout_last = 1'b0;
        rx_q      = 32'h0;
        strb_q    = 32'h0;
    end

    task automatic cs_set(input logic en);
        #(HALF_NS);
        cs_n_out = ~en;
        #(HALF_NS);
    endtask

    // Clock idles low; data set while low, both sides sample on the rise
    task automatic shift(input logic [31:0] tx, input int n);
        for (int i = 0; i < n; i++)
        begin
            din_out = tx[n-1-i];
            #(HALF_NS);
            sclk_out = 1'b1;
            // A released line does not keep its last level
            rx_q   = {rx_q[30:0], dout_oe_in ? dout_in : ~dout_last};
            strb_q = {strb_q[30:0], strobe_oe_in ? strobe_in : ~strb_q[0]};
            if (dout_oe_in)
                dout_last = dout_in;
            #(HALF_NS);
            sclk_out = 1'b0;
        end
        #(HALF_NS);
    endtask
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the converter serial sequencer.
// Assumes the host model drives the pins; the comparator is modelled here.
`timescale 1ns/10ps
`define check_eq(act, exp) begin checks++; if ((act) !== (exp)) begin failures++; \
    $display("CHECK FAILED t=%0t act=%h exp=%h", $time, (act), (exp)); end end
module testbench;
    import adc_seq_pkg::*;
    // ********************************************************************
    // Signals and instances
    // ********************************************************************
    logic       ref_clk_in = 1'b0;
    logic       rst_n_in;
    wire        cs_n, sclk, din, dout_out, dout_oe_out;
    wire        conversion_strobe_out, conversion_strobe_oe_out;
    wire  [9:0] sar_trial_out;
    logic [9:0] vin;
    wire mux_sel_s mux_out;
    wire        track_out, converting_out, power_down_out;
    wire  [1:0] pwr_mode_out;
    int         failures = 0;
    int         checks = 0;
    wire        comp_in = (vin >= sar_trial_out);

    always #5 ref_clk_in = ~ref_clk_in;

    adc_serial_control_sequencer dut_u (
        .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .cs_n_in(cs_n), .sclk_in(sclk),
        .din_in(din), .dout_out(dout_out), .dout_oe_out(dout_oe_out),
        .conversion_strobe_out(conversion_strobe_out),
        .conversion_strobe_oe_out(conversion_strobe_oe_out), .comp_in(comp_in),
        .sar_trial_out(sar_trial_out), .mux_out(mux_out), .track_out(track_out),
        .converting_out(converting_out), .pwr_mode_out(pwr_mode_out),
        .power_down_out(power_down_out)
    );

    host_spi_model host_u (
        .cs_n_out(cs_n), .sclk_out(sclk), .din_out(din), .dout_in(dout_out),
        .dout_oe_in(dout_oe_out), .strobe_in(conversion_strobe_out),
        .strobe_oe_in(conversion_strobe_oe_out)
    );

    // ********************************************************************
    // Helpers
    // ********************************************************************
    function automatic logic [7:0] ctrl_byte(logic [2:0] sel, logic uni, logic sgl, logic [1:0] mode);
        return {1'b1, sel, uni, sgl, mode};
    endfunction

    task automatic complete_run();
        if (failures == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic run_ext(input logic [7:0] ctrl, input logic [9:0] code, input logic [9:0] res,
                           input logic [1:0] pos, input int lead);
        mux_sel_s m;
        m.pos_chan   = pos;
        m.neg_chan   = pos ^ 2'h1;
        m.neg_is_com = ctrl[2];
        @(negedge ref_clk_in) vin = code;
        host_u.cs_set(1'b1);
        host_u.shift(32'h0, lead);
        host_u.shift({27'h0, ctrl[7:3]}, 5);
        `check_eq(track_out, 1'b1)
        `check_eq(mux_out.pos_chan, pos)
        host_u.shift({29'h0, ctrl[2:0]}, 3);
        `check_eq(track_out, 1'b0)
        `check_eq(mux_out, m)
        `check_eq(converting_out, 1'b1)
        host_u.shift(32'h0, 16);
        `check_eq(host_u.rx_q[15:0], {1'b0, res, 5'h00})
        `check_eq(host_u.strb_q[15:0], 16'h8000)
        host_u.cs_set(1'b0);
        `check_eq(dout_oe_out, 1'b0)
        `check_eq(conversion_strobe_oe_out, 1'b0)
    endtask

    // ********************************************************************
    // Scenarios
    // ********************************************************************
    task automatic test_reset_state();
        `check_eq(conversion_strobe_out, 1'b1)
        `check_eq(pwr_mode_out, MODE_INT_CLK)
        `check_eq(power_down_out, 1'b0)
        host_u.cs_set(1'b1);
        host_u.shift(32'h0, 16);
        `check_eq(host_u.rx_q[15:0], 16'h0000)
        `check_eq(converting_out, 1'b0)
        host_u.cs_set(1'b0);
    endtask

    task automatic test_channels();
        logic [2:0] sel_tbl [4];
        logic [9:0] code_tbl [4];
        sel_tbl  = '{3'h1, 3'h5, 3'h2, 3'h6};
        code_tbl = '{10'h000, 10'h3ff, 10'h155, 10'h2aa};
        for (int s = 0; s < 2; s++)
            for (int i = 0; i < 4; i++)
                run_ext(ctrl_byte(sel_tbl[i], 1'b1, s[0], MODE_EXT_CLK), code_tbl[i], code_tbl[i],
                        i[1:0], (i == 2) ? 3 : 0);
    endtask

    task automatic test_bipolar();
        run_ext(ctrl_byte(3'h2, 1'b0, 1'b1, MODE_EXT_CLK), 10'h000, 10'h200, 2'h2, 0);
        run_ext(ctrl_byte(3'h6, 1'b0, 1'b0, MODE_EXT_CLK), 10'h3ff, 10'h1ff, 2'h3, 0);
    endtask

    task automatic test_power_modes();
        for (int m = 0; m < 2; m++)
        begin
            host_u.cs_set(1'b1);
            host_u.shift({24'h0, ctrl_byte(3'h1, 1'b1, 1'b1, m[1:0])}, 8);
            `check_eq(pwr_mode_out, m[1:0])
            `check_eq(power_down_out, 1'b1)
            `check_eq(converting_out, 1'b0)
            host_u.cs_set(1'b0);
        end
    endtask

    task automatic test_internal();
        int n;
        @(negedge ref_clk_in) vin = 10'h1c3;
        host_u.cs_set(1'b1);
        host_u.shift({24'h0, ctrl_byte(3'h1, 1'b1, 1'b1, MODE_INT_CLK)}, 8);
        `check_eq(pwr_mode_out, MODE_INT_CLK)
        `check_eq(conversion_strobe_out, 1'b0)
        n = 0;
        while (conversion_strobe_out !== 1'b1 && n < 1000)
        begin
            @(negedge ref_clk_in);
            n++;
        end
        `check_eq(n <= INT_CONV_MAX_CYC, 1'b1)
        host_u.shift(32'h0, 16);
        `check_eq(host_u.rx_q[15:0], {1'b0, 10'h1c3, 5'h00})
        host_u.cs_set(1'b0);
        `check_eq(conversion_strobe_oe_out, 1'b1)
    endtask

    task automatic test_abort();
        @(negedge ref_clk_in) vin = 10'h0f0;
        host_u.cs_set(1'b1);
        host_u.shift({24'h0, ctrl_byte(3'h5, 1'b1, 1'b1, MODE_EXT_CLK)}, 8);
        host_u.shift(32'h0, 2);
        host_u.cs_set(1'b0);
        run_ext(ctrl_byte(3'h6, 1'b1, 1'b1, MODE_EXT_CLK), 10'h30c, 10'h30c, 2'h3, 0);
    endtask

    // New byte accepted with select held low once four result bits are out
    task automatic test_overlap();
        @(negedge ref_clk_in) vin = 10'h2c5;
        host_u.cs_set(1'b1);
        host_u.shift({24'h0, ctrl_byte(3'h1, 1'b1, 1'b1, MODE_EXT_CLK)}, 8);
        host_u.shift(32'h0, 4);
        host_u.shift({24'h0, ctrl_byte(3'h2, 1'b1, 1'b1, MODE_EXT_CLK)}, 8);
        `check_eq(mux_out.pos_chan, 2'h2)
        host_u.shift(32'h0, 16);
        `check_eq(host_u.rx_q[15:0], {1'b0, 10'h2c5, 5'h00})
        host_u.cs_set(1'b0);
    endtask

    // ********************************************************************
    // Main sequence and watchdog
    // ********************************************************************
    initial
    begin
        rst_n_in = 1'b0;
        vin      = 10'h000;
        repeat (8) @(posedge ref_clk_in);
        @(negedge ref_clk_in) rst_n_in = 1'b1;
        repeat (3) @(negedge ref_clk_in);
        test_reset_state();
        test_channels();
        test_bipolar();
        test_power_modes();
        test_internal();
        test_abort();
        test_overlap();
        complete_run();
    end

    // About 17 transfers of up to 6.4 us each plus one internal conversion
    initial
    begin
        #500000;
        failures++;
        complete_run();
    end
endmodule
